// >>> inc/ipr_cfg.svh
// constants for the priority control register four block
`ifndef IPR_CFG_SVH
`define IPR_CFG_SVH
`define IPR_ADDR_W          4
`define IPR_DATA_W          16
`define IPR_OFS_PRIO_FOUR   4'h0
`define IPR_OFS_PRIO_STATUS 4'h1
`define IPR_FLD_W           3
`define IPR_CN_LSB          12
`define IPR_CM_LSB          8
`define IPR_MI2C_LSB        4
`define IPR_SI2C_LSB        0
`define IPR_FLD_RESET       3'h4
`define IPR_NUM_SRC         4
`endif

// >>> inc/ipr_pkg.sv
// types for the priority control register four block
package ipr_pkg;
    typedef logic [2:0] ipr_prio_t;
    typedef enum logic [1:0] {
        IPR_SRC_SI2C,
        IPR_SRC_MI2C,
        IPR_SRC_CM,
        IPR_SRC_CN
    } ipr_src_t;
endpackage

// >>> rtl/ipr_field_decode.sv
// decode of one 3-bit priority field
`timescale 1ns/1ps
`default_nettype none
module ipr_field_decode
    import ipr_pkg::*;
(
    input  wire ipr_prio_t prioField,
    output logic           srcEnabled,
    output logic           isHighest
);
    // zero disables the source, seven is top
    assign srcEnabled = (prioField != 3'h0);
    assign isHighest  = (prioField == 3'h7);
endmodule
`default_nettype wire

// >>> rtl/ipr_priority_reg.sv
// priority control register four with decoded source priorities
`include "ipr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ipr_priority_reg
    import ipr_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic [`IPR_ADDR_W-1:0] regAddr,
    input  wire logic [`IPR_DATA_W-1:0] regWdata,
    input  wire logic                   regWrite,
    input  wire logic                   regRead,
    output logic      [`IPR_DATA_W-1:0] regRdata,
    output ipr_prio_t                   changeNotifyPriority,
    output ipr_prio_t                   comparatorPriority,
    output ipr_prio_t                   i2cMasterEventPriority,
    output ipr_prio_t                   i2cSlaveEventPriority,
    output logic      [`IPR_NUM_SRC-1:0] srcEnabled
);
    // ==========================================
    // priority fields
    ipr_prio_t cnPrio_q, cnPrio_d;
    ipr_prio_t cmPrio_q, cmPrio_d;
    ipr_prio_t miPrio_q, miPrio_d;
    ipr_prio_t siPrio_q, siPrio_d;
    logic      wrFour;

    assign wrFour = regWrite && (regAddr == `IPR_OFS_PRIO_FOUR);

    always_comb begin
        cnPrio_d = cnPrio_q;
        cmPrio_d = cmPrio_q;
        miPrio_d = miPrio_q;
        siPrio_d = siPrio_q;
        if (wrFour) begin
            cnPrio_d = regWdata[`IPR_CN_LSB +: `IPR_FLD_W];
            cmPrio_d = regWdata[`IPR_CM_LSB +: `IPR_FLD_W];
            miPrio_d = regWdata[`IPR_MI2C_LSB +: `IPR_FLD_W];
            siPrio_d = regWdata[`IPR_SI2C_LSB +: `IPR_FLD_W];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnPrio_q <= `IPR_FLD_RESET;
            cmPrio_q <= `IPR_FLD_RESET;
            miPrio_q <= `IPR_FLD_RESET;
            siPrio_q <= `IPR_FLD_RESET;
        end else begin
            cnPrio_q <= cnPrio_d;
            cmPrio_q <= cmPrio_d;
            miPrio_q <= miPrio_d;
            siPrio_q <= siPrio_d;
        end
    end

    assign changeNotifyPriority   = cnPrio_q;
    assign comparatorPriority     = cmPrio_q;
    assign i2cMasterEventPriority = miPrio_q;
    assign i2cSlaveEventPriority  = siPrio_q;

    // ==========================================
    // per-source decode
    ipr_prio_t fieldArr [`IPR_NUM_SRC];
    logic [`IPR_NUM_SRC-1:0] isTop;
    assign fieldArr[IPR_SRC_SI2C] = siPrio_q;
    assign fieldArr[IPR_SRC_MI2C] = miPrio_q;
    assign fieldArr[IPR_SRC_CM]   = cmPrio_q;
    assign fieldArr[IPR_SRC_CN]   = cnPrio_q;

    for (genvar i = 0; i < `IPR_NUM_SRC; i++) begin : g_dec
        ipr_field_decode u_dec (
            .prioField  (fieldArr[i]),
            .srcEnabled (srcEnabled[i]),
            .isHighest  (isTop[i])
        );
    end

    // ==========================================
    // read path, data one cycle after strobe
    logic [`IPR_DATA_W-1:0] rdata_q, rdata_d;
    logic [`IPR_DATA_W-1:0] regImage;

    always_comb begin
        regImage = '0;
        regImage[`IPR_CN_LSB +: `IPR_FLD_W]   = cnPrio_q;
        regImage[`IPR_CM_LSB +: `IPR_FLD_W]   = cmPrio_q;
        regImage[`IPR_MI2C_LSB +: `IPR_FLD_W] = miPrio_q;
        regImage[`IPR_SI2C_LSB +: `IPR_FLD_W] = siPrio_q;
        rdata_d = '0;
        if (regRead) begin
            if (regAddr == `IPR_OFS_PRIO_FOUR) begin
                rdata_d = regImage;
            end else if (regAddr == `IPR_OFS_PRIO_STATUS) begin
                // low nibble enabled, next nibble top priority
                rdata_d = {8'h00, isTop, srcEnabled};
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign regRdata = rdata_q;

    // ==========================================
    // checks
    sequence s_wrFour;
        regWrite && (regAddr == `IPR_OFS_PRIO_FOUR);
    endsequence

    sequence s_rdFour;
        regRead && (regAddr == `IPR_OFS_PRIO_FOUR);
    endsequence

    property p_cnWrite;
        @(posedge core_clk) disable iff (!resetn)
        s_wrFour |=> changeNotifyPriority == $past(regWdata[14:12]);
    endproperty
    a_cnWrite: assert property (p_cnWrite) else $error("cn field not written");

    property p_cmWrite;
        @(posedge core_clk) disable iff (!resetn)
        s_wrFour |=> comparatorPriority == $past(regWdata[10:8]);
    endproperty
    a_cmWrite: assert property (p_cmWrite) else $error("cm field not written");

    property p_i2cWrite;
        @(posedge core_clk) disable iff (!resetn)
        s_wrFour |=> i2cMasterEventPriority == $past(regWdata[6:4])
            && i2cSlaveEventPriority == $past(regWdata[2:0]);
    endproperty
    a_i2cWrite: assert property (p_i2cWrite) else $error("i2c fields not written");

    property p_holdNoWrite;
        @(posedge core_clk) disable iff (!resetn)
        !regWrite |=> $stable(changeNotifyPriority) && $stable(comparatorPriority);
    endproperty
    a_holdNoWrite: assert property (p_holdNoWrite) else $error("field changed without write");

    property p_readBack;
        @(posedge core_clk) disable iff (!resetn)
        s_rdFour ##0 !regWrite |=> regRdata == {1'b0, $past(cnPrio_q), 1'b0, $past(cmPrio_q),
            1'b0, $past(miPrio_q), 1'b0, $past(siPrio_q)};
    endproperty
    a_readBack: assert property (p_readBack) else $error("read image wrong");

    property p_unusedZero;
        @(posedge core_clk) disable iff (!resetn)
        s_rdFour |=> regRdata[15] == 1'b0 && regRdata[11] == 1'b0
            && regRdata[7] == 1'b0 && regRdata[3] == 1'b0;
    endproperty
    a_unusedZero: assert property (p_unusedZero) else $error("unimplemented bit set");

    property p_enableDecode;
        @(posedge core_clk) disable iff (!resetn)
        srcEnabled == {changeNotifyPriority != 3'h0, comparatorPriority != 3'h0,
            i2cMasterEventPriority != 3'h0, i2cSlaveEventPriority != 3'h0}
            && isTop == {changeNotifyPriority == 3'h7, comparatorPriority == 3'h7,
            i2cMasterEventPriority == 3'h7, i2cSlaveEventPriority == 3'h7};
    endproperty
    a_enableDecode: assert property (p_enableDecode) else $error("priority decode wrong");

    property p_resetValue;
        @(posedge core_clk)
        $rose(resetn) |-> changeNotifyPriority == 3'h4 && comparatorPriority == 3'h4
            && i2cMasterEventPriority == 3'h4 && i2cSlaveEventPriority == 3'h4;
    endproperty
    a_resetValue: assert property (p_resetValue) else $error("reset value wrong");

    property p_resetHeld;
        @(posedge core_clk)
        !resetn |=> changeNotifyPriority == 3'h4 && comparatorPriority == 3'h4
            && i2cMasterEventPriority == 3'h4 && i2cSlaveEventPriority == 3'h4;
    endproperty
    a_resetHeld: assert property (p_resetHeld) else $error("field not at reset value");

    sequence s_rdStatus;
        regRead && (regAddr == `IPR_OFS_PRIO_STATUS);
    endsequence

    // fields cannot move in the cycle after a status read, regAddr then rules out a write to register four
    property p_statusRead;
        @(posedge core_clk) disable iff (!resetn)
        s_rdStatus |=> regRdata == {8'h00, changeNotifyPriority == 3'h7, comparatorPriority == 3'h7,
            i2cMasterEventPriority == 3'h7, i2cSlaveEventPriority == 3'h7,
            changeNotifyPriority != 3'h0, comparatorPriority != 3'h0,
            i2cMasterEventPriority != 3'h0, i2cSlaveEventPriority != 3'h0};
    endproperty
    a_statusRead: assert property (p_statusRead) else $error("status image wrong");

    property p_strayWriteHold;
        @(posedge core_clk) disable iff (!resetn)
        !wrFour |=> $stable(changeNotifyPriority) && $stable(comparatorPriority)
            && $stable(i2cMasterEventPriority) && $stable(i2cSlaveEventPriority);
    endproperty
    a_strayWriteHold: assert property (p_strayWriteHold) else $error("field moved without write");

    property p_readIdle;
        @(posedge core_clk) disable iff (!resetn)
        !regRead |=> regRdata == 16'h0000;
    endproperty
    a_readIdle: assert property (p_readIdle) else $error("read data not zero when idle");

    property p_unmappedRead;
        @(posedge core_clk) disable iff (!resetn)
        regRead && regAddr != `IPR_OFS_PRIO_FOUR && regAddr != `IPR_OFS_PRIO_STATUS
            |=> regRdata == 16'h0000;
    endproperty
    a_unmappedRead: assert property (p_unmappedRead) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> testbench/ipr_priority_reg_test.sv
// self-checking bench for the priority control register four block
`include "ipr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ipr_priority_reg_test
    import ipr_pkg::*;
;
    logic                    core_clk = 1'b0;
    logic                    resetn   = 1'b0;
    logic [`IPR_ADDR_W-1:0]  regAddr  = 4'h0;
    logic [`IPR_DATA_W-1:0]  regWdata = 16'h0000;
    logic                    regWrite = 1'b0;
    logic                    regRead  = 1'b0;
    logic [`IPR_DATA_W-1:0]  regRdata;
    ipr_prio_t               cnPrio;
    ipr_prio_t               cmPrio;
    ipr_prio_t               miPrio;
    ipr_prio_t               siPrio;
    logic [`IPR_NUM_SRC-1:0] srcEnabled;
    wire logic [15:0]        fieldView = {cnPrio, cmPrio, miPrio, siPrio, srcEnabled};
    int                      num_errors = 0;
    int                      samples_checked = 0;
    int                      cycles = 0;

    always #2 core_clk = ~core_clk;

    ipr_priority_reg DUT (
        .core_clk              (core_clk),
        .resetn                (resetn),
        .regAddr               (regAddr),
        .regWdata              (regWdata),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regRdata              (regRdata),
        .changeNotifyPriority  (cnPrio),
        .comparatorPriority    (cmPrio),
        .i2cMasterEventPriority(miPrio),
        .i2cSlaveEventPriority (siPrio),
        .srcEnabled            (srcEnabled)
    );

    // ==========================================
    // helpers
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 chk(regRdata, exp, "read data");
        @(posedge core_clk);
        #1 chk(regRdata, 16'h0000, "read data not cleared");
    endtask

    // write, then compare outputs, register and status
    task automatic step(input logic [15:0] d, input logic [15:0] view, input logic [15:0] stat);
        wr(`IPR_OFS_PRIO_FOUR, d);
        chk(fieldView, view, "field outputs");
        rd(`IPR_OFS_PRIO_FOUR, d & 16'h7777);
        rd(`IPR_OFS_PRIO_STATUS, stat);
    endtask

    // ==========================================
    // scenarios
    task automatic test_reset();
        chk(fieldView, {3'h4, 3'h4, 3'h4, 3'h4, 4'hF}, "reset fields");
        rd(`IPR_OFS_PRIO_FOUR, 16'h4444);
        rd(`IPR_OFS_PRIO_STATUS, 16'h000F);
    endtask

    task automatic test_decode();
        step(16'hFFFF, 16'hFFFF, 16'h00FF);
        step(16'h7010, {3'h7, 3'h0, 3'h1, 3'h0, 4'hA}, 16'h008A);
        step(16'h0107, {3'h0, 3'h1, 3'h0, 3'h7, 4'h5}, 16'h0015);
        step(16'h0000, 16'h0000, 16'h0000);
        step(16'h3625, {3'h3, 3'h6, 3'h2, 3'h5, 4'hF}, 16'h000F);
    endtask

    task automatic test_refused();
        wr(`IPR_OFS_PRIO_STATUS, 16'h0000);
        wr(4'hF, 16'h0000);
        chk(fieldView, {3'h3, 3'h6, 3'h2, 3'h5, 4'hF}, "stray write");
        rd(4'h2, 16'h0000);
        rd(`IPR_OFS_PRIO_FOUR, 16'h3625);
    endtask

    // reset in mid-run brings every field back to level 4
    task automatic test_mid_reset();
        wr(`IPR_OFS_PRIO_FOUR, 16'h1234);
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk(fieldView, {3'h4, 3'h4, 3'h4, 3'h4, 4'hF}, "fields in reset");
        @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        test_reset();
    endtask

    // ==========================================
    // sequence and timeout
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 2000) begin
            num_errors++;
            $display("[FAIL] %0t timeout", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        #1;
        test_reset();
        test_decode();
        test_refused();
        test_mid_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
